// [hw/mvoc_top.sv]
/*
 * Output conditioning: source priority, limits, slew limiting, heat/cool
 * split and PV square-root extraction, configured over APB.
 * Assumes calculated MV, PV and error flag are synchronous to i_mclk.
 */
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module mvoc_top #(
    parameter int P_TICK_CYC = mvoc_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // APB slave
    input wire mvoc_pkg::mvoc_apb_req_t i_apb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Process side
    input wire logic signed [15:0] i_calc_mv,
    input wire logic signed [15:0] i_pv_in,
    input wire logic i_pv_err,
    // Conditioned outputs
    output logic signed [15:0] o_mv,
    output logic [15:0] o_heat,
    output logic [15:0] o_cool,
    output logic signed [15:0] o_pv
);
    import mvoc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic signed [VAL_W-1:0] sat(input logic signed [VAL_W-1:0] v,
                                                   input logic signed [VAL_W-1:0] lo,
                                                   input logic signed [VAL_W-1:0] hi);
        if (v < lo)
            sat = lo;
        else if (v > hi)
            sat = hi;
        else
            sat = v;
    endfunction

    function automatic logic [9:0] isqrt(input logic [19:0] v);
        logic [9:0] r;
        logic [9:0] t;
        r = 10'h000;
        for (int b = 9; b >= 0; b--)
        begin
            t = r | (10'h001 << b);
            if ({10'h000, t} * {10'h000, t} <= v)
                r = t;
        end
        isqrt = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers
    mvoc_ctrl_t ctrl_ff, nxt_ctrl;
    logic signed [VAL_W-1:0] hi_ff, nxt_hi, lo_ff, nxt_lo, stop_ff, nxt_stop;
    logic signed [VAL_W-1:0] err_ff, nxt_err, man_ff, nxt_man, rate_ff, nxt_rate;
    logic signed [VAL_W-1:0] cut_ff, nxt_cut;
    logic wr_en, rd_hit;
    logic signed [VAL_W-1:0] wv;

    assign wr_en = i_apb.psel && i_apb.penable && i_apb.pwrite;
    assign wv = i_apb.pwdata[VAL_W-1:0];
    // Zero-wait slave: every access completes in its first access cycle
    assign o_pready = 1'b1;

    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        nxt_hi = hi_ff;
        nxt_lo = lo_ff;
        nxt_stop = stop_ff;
        nxt_err = err_ff;
        nxt_man = man_ff;
        nxt_rate = rate_ff;
        nxt_cut = cut_ff;
        if (wr_en)
        begin
            if (i_apb.paddr == REG_CTRL)
                nxt_ctrl = mvoc_ctrl_t'(i_apb.pwdata[6:0]);
            else if (i_apb.paddr == REG_MV_HI)
                nxt_hi = sat(wv, PCT_NEG105, PCT_105);
            else if (i_apb.paddr == REG_MV_LO)
                nxt_lo = sat(wv, PCT_NEG105, PCT_105);
            else if (i_apb.paddr == REG_STOP_MV)
                nxt_stop = sat(wv, PCT_NEG105, PCT_105);
            else if (i_apb.paddr == REG_ERR_MV)
                nxt_err = sat(wv, PCT_NEG105, PCT_105);
            else if (i_apb.paddr == REG_MAN_MV)
                nxt_man = sat(wv, PCT_NEG105, PCT_105);
            else if (i_apb.paddr == REG_RATE)
                nxt_rate = sat(wv, PCT_0, PCT_100);
            else if (i_apb.paddr == REG_LOWCUT)
                nxt_cut = sat(wv, PCT_0, PCT_100);
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            ctrl_ff <= CTRL_RST;
            hi_ff <= MV_HI_RST;
            lo_ff <= MV_LO_RST;
            stop_ff <= ZERO_RST;
            err_ff <= ZERO_RST;
            man_ff <= ZERO_RST;
            rate_ff <= ZERO_RST;
            cut_ff <= ZERO_RST;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
            hi_ff <= nxt_hi;
            lo_ff <= nxt_lo;
            stop_ff <= nxt_stop;
            err_ff <= nxt_err;
            man_ff <= nxt_man;
            rate_ff <= nxt_rate;
            cut_ff <= nxt_cut;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Source selection and limits
    mvoc_src_t src;
    logic signed [VAL_W-1:0] lo_rng, stop_use, err_use, man_use, calc_lim, sel_mv;
    logic bypass;

    always_comb
    begin
        // Stop and error values are ranged by control type at use time
        lo_rng = ctrl_ff.heat_cool ? PCT_NEG105 : PCT_NEG5;
        stop_use = sat(stop_ff, lo_rng, PCT_105);
        err_use = sat(err_ff, lo_rng, PCT_105);
        man_use = ctrl_ff.man_lim_en ? sat(man_ff, lo_ff, hi_ff) : man_ff;
        calc_lim = sat(i_calc_mv, lo_ff, hi_ff);
        if (ctrl_ff.manual)
        begin
            src = SRC_MAN;
            sel_mv = man_use;
        end
        else if (ctrl_ff.stop)
        begin
            src = SRC_STOP;
            sel_mv = stop_use;
        end
        else if (i_pv_err)
        begin
            src = SRC_ERR;
            sel_mv = err_use;
        end
        else
        begin
            src = SRC_CALC;
            sel_mv = calc_lim;
        end
        bypass = (src != SRC_CALC) || ctrl_ff.autotune || ctrl_ff.onoff
                 || (rate_ff == PCT_0);
    end

    ////////////////////////////////////////////////////////////////////////
    // Slew limiter, stepped once per control period
    logic [TICK_W-1:0] tick_ff, nxt_tick;
    logic signed [ACC_W-1:0] acc_ff, nxt_acc, tgt_m, diff, step;
    logic signed [VAL_W-1:0] mv_ff, nxt_mv;
    logic tick;

    always_comb
    begin
        tick = (tick_ff == TICK_W'(P_TICK_CYC - 1));
        nxt_tick = tick ? '0 : tick_ff + TICK_W'(1);
        tgt_m = ACC_W'(sel_mv) * ACC_W'(MILLI_PER_TENTH);
        step = ACC_W'(rate_ff) * ACC_W'(STEP_MUL);
        diff = tgt_m - acc_ff;
        nxt_acc = acc_ff;
        if (bypass)
            nxt_acc = tgt_m;
        else if (tick)
        begin
            if (diff > step)
                nxt_acc = acc_ff + step;
            else if (diff < -step)
                nxt_acc = acc_ff - step;
            else
                nxt_acc = tgt_m;
        end
        nxt_mv = VAL_W'(nxt_acc / ACC_W'(MILLI_PER_TENTH));
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            tick_ff <= '0;
            acc_ff <= '0;
            mv_ff <= ZERO_RST;
        end
        else
        begin
            tick_ff <= nxt_tick;
            acc_ff <= nxt_acc;
            mv_ff <= nxt_mv;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Heat/cool split and PV square root
    logic [VAL_W-1:0] heat_ff, nxt_heat, cool_ff, nxt_cool;
    logic signed [VAL_W-1:0] pv_ff, nxt_pv;
    logic [19:0] sq_arg;

    always_comb
    begin
        nxt_heat = VAL_W'(0);
        nxt_cool = VAL_W'(0);
        if (!ctrl_ff.heat_cool)
            nxt_heat = (nxt_mv > PCT_0) ? nxt_mv : PCT_0;
        else if (nxt_mv < PCT_0)
            nxt_cool = -nxt_mv;
        else
            nxt_heat = nxt_mv;
        // Arithmetic only for 0..100 %; other inputs never use it
        sq_arg = 20'(i_pv_in[10:0]) * 20'(SQRT_SCALE);
        if (!ctrl_ff.sqrt_en || i_pv_in < PCT_0 || i_pv_in > PCT_100)
            nxt_pv = i_pv_in;
        else if (i_pv_in < cut_ff)
            nxt_pv = PCT_0;
        else
            nxt_pv = VAL_W'(isqrt(sq_arg));
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            heat_ff <= '0;
            cool_ff <= '0;
            pv_ff <= ZERO_RST;
        end
        else
        begin
            heat_ff <= nxt_heat;
            cool_ff <= nxt_cool;
            pv_ff <= nxt_pv;
        end
    end

    assign o_mv = mv_ff;
    assign o_heat = heat_ff;
    assign o_cool = cool_ff;
    assign o_pv = pv_ff;
    ////////////////////////////////////////////////////////////////////////
    // Read path; unmapped addresses answer with an error
    always_comb
    begin
        rd_hit = 1'b1;
        o_prdata = 32'h0000_0000;
        if (i_apb.paddr == REG_CTRL)
            o_prdata = 32'(ctrl_ff);
        else if (i_apb.paddr == REG_MV_HI)
            o_prdata = 32'($unsigned(hi_ff));
        else if (i_apb.paddr == REG_MV_LO)
            o_prdata = 32'($unsigned(lo_ff));
        else if (i_apb.paddr == REG_STOP_MV)
            o_prdata = 32'($unsigned(stop_ff));
        else if (i_apb.paddr == REG_ERR_MV)
            o_prdata = 32'($unsigned(err_ff));
        else if (i_apb.paddr == REG_MAN_MV)
            o_prdata = 32'($unsigned(man_ff));
        else if (i_apb.paddr == REG_RATE)
            o_prdata = 32'($unsigned(rate_ff));
        else if (i_apb.paddr == REG_LOWCUT)
            o_prdata = 32'($unsigned(cut_ff));
        else if (i_apb.paddr == REG_STATUS)
            o_prdata = {29'h0000_0000, bypass, src};
        else if (i_apb.paddr == REG_MV_OUT)
            o_prdata = 32'($unsigned(mv_ff));
        else if (i_apb.paddr == REG_PV_OUT)
            o_prdata = 32'($unsigned(pv_ff));
        else
            rd_hit = 1'b0;
    end
    assign o_pslverr = i_apb.psel && i_apb.penable && !rd_hit;
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    AST_CALC_CLAMP: assert property ((src == SRC_CALC && bypass) |=>
        (o_mv >= $past(lo_ff) && o_mv <= $past(hi_ff)))
        else $error("calculated value left its limits");
    AST_MAN_FIRST: assert property (ctrl_ff.manual && !ctrl_ff.man_lim_en |=>
        o_mv == $past(man_ff))
        else $error("manual value not output unclamped");
    AST_MAN_LIMIT: assert property (ctrl_ff.manual && ctrl_ff.man_lim_en |=>
        (o_mv >= $past(lo_ff) && o_mv <= $past(hi_ff)))
        else $error("limited manual value outside limits");
    AST_PRIORITY: assert property (!ctrl_ff.manual && ctrl_ff.stop |=>
        o_mv == $past(stop_use))
        else $error("stop value lost its priority");
    AST_STOP_RANGE: assert property (ctrl_ff.stop && !ctrl_ff.manual && !ctrl_ff.heat_cool
        |=> o_mv >= PCT_NEG5 && o_mv <= PCT_105)
        else $error("stop value outside standard range");
    AST_ERR_OUT: assert property (src == SRC_ERR |=> o_mv == $past(err_use))
        else $error("error value not output");
    AST_SPLIT: assert property (ctrl_ff.heat_cool |=>
        ((o_mv < PCT_0) ? (o_cool == -o_mv && o_heat == '0)
                        : (o_heat == o_mv && o_cool == '0)))
        else $error("heat/cool steering wrong");
    AST_SQRT_OFF: assert property (!ctrl_ff.sqrt_en |=> o_pv == $past(i_pv_in))
        else $error("square root active while disabled");
    AST_LOWCUT: assert property (ctrl_ff.sqrt_en && i_pv_in > PCT_0 && i_pv_in < cut_ff
        |=> o_pv == PCT_0)
        else $error("low-cut did not give zero");
    AST_PASS: assert property (i_pv_in > PCT_100 || i_pv_in < PCT_0 |=>
        o_pv == $past(i_pv_in))
        else $error("out of range input not passed");
    AST_SQRT_VAL: assert property (ctrl_ff.sqrt_en && i_pv_in == 16'sh0064 && cut_ff <= i_pv_in
        |=> o_pv == 16'sh013c)
        else $error("square root of ten percent wrong");
    AST_SLEW_HOLD: assert property (!bypass && !tick |=> acc_ff == $past(acc_ff))
        else $error("slew moved between periods");
    AST_SLEW_STEP: assert property (!bypass && tick && (diff > step)
        |=> acc_ff == $past(acc_ff) + $past(step))
        else $error("slew step wrong");
    AST_RATE_ZERO: assert property (rate_ff == PCT_0 |=> acc_ff == $past(tgt_m))
        else $error("zero rate still slewing");
    AST_NO_SLEW: assert property (ctrl_ff.autotune || ctrl_ff.onoff
        |=> acc_ff == $past(tgt_m))
        else $error("slew active while bypassed");
    CV_SLEW: cover property (!bypass && tick && diff > step);
    CV_MAN: cover property (src == SRC_MAN && ctrl_ff.man_lim_en);
    CV_ERR: cover property (src == SRC_ERR && ctrl_ff.heat_cool && err_ff < PCT_0);
    CV_SQRT: cover property (ctrl_ff.sqrt_en && i_pv_in >= cut_ff && i_pv_in > PCT_0);
endmodule

// [include/mvoc_pkg.sv]
/*
 * Constants and types for the manipulated-value output conditioning block.
 * Assumes values in signed 0.1 % steps and one 200 MHz control clock.
 */
package mvoc_pkg;
    localparam int VAL_W = 16;
    localparam int ACC_W = 24;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_MV_HI = 8'h04;
    localparam logic [7:0] REG_MV_LO = 8'h08;
    localparam logic [7:0] REG_STOP_MV = 8'h0c;
    localparam logic [7:0] REG_ERR_MV = 8'h10;
    localparam logic [7:0] REG_MAN_MV = 8'h14;
    localparam logic [7:0] REG_RATE = 8'h18;
    localparam logic [7:0] REG_LOWCUT = 8'h1c;
    localparam logic [7:0] REG_STATUS = 8'h20;
    localparam logic [7:0] REG_MV_OUT = 8'h24;
    localparam logic [7:0] REG_PV_OUT = 8'h28;
    localparam logic signed [VAL_W-1:0] PCT_0 = 16'sh0000;
    localparam logic signed [VAL_W-1:0] PCT_100 = 16'sh03e8;
    localparam logic signed [VAL_W-1:0] PCT_105 = 16'sh041a;
    localparam logic signed [VAL_W-1:0] PCT_NEG5 = -16'sh0032;
    localparam logic signed [VAL_W-1:0] PCT_NEG105 = -16'sh041a;
    localparam logic signed [VAL_W-1:0] MV_HI_RST = 16'sh03e8;
    localparam logic signed [VAL_W-1:0] MV_LO_RST = 16'sh0000;
    localparam logic signed [VAL_W-1:0] ZERO_RST = 16'sh0000;
    localparam int MILLI_PER_TENTH = 100;
    localparam int SQRT_SCALE = 1000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int CTRL_PERIOD_MS = 100;
    localparam int TICK_CYCLES = CTRL_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int STEP_MUL = CTRL_PERIOD_MS / 10;
    localparam int TICK_W = 25;
    typedef struct packed {
        logic onoff;
        logic autotune;
        logic stop;
        logic manual;
        logic heat_cool;
        logic man_lim_en;
        logic sqrt_en;
    } mvoc_ctrl_t;
    localparam mvoc_ctrl_t CTRL_RST = 7'h00;
    typedef enum logic [1:0] {
        SRC_CALC = 2'b00,
        SRC_ERR = 2'b01,
        SRC_STOP = 2'b11,
        SRC_MAN = 2'b10
    } mvoc_src_t;
    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } mvoc_apb_req_t;
endpackage

// [test/mv_output_conditioning_test.sv]
/*
 * Self-checking bench for the output conditioning block: APB register
 * access, source priority, limits, heat/cool split, square root, slew.
 * Assumes the package constants and a shortened control period of 16 cycles.
 */
`timescale 1ns/1ps
module mv_output_conditioning_test;
    import mvoc_pkg::*;
    localparam int TICK = 16;
    logic i_mclk;
    logic i_rst_n;
    mvoc_apb_req_t i_apb;
    logic [31:0] o_prdata;
    logic o_pready;
    logic o_pslverr;
    logic signed [15:0] i_calc_mv;
    logic signed [15:0] i_pv_in;
    logic i_pv_err;
    logic signed [15:0] o_mv;
    logic [15:0] o_heat;
    logic [15:0] o_cool;
    logic signed [15:0] o_pv;
    int fails;
    int checked;
    int n;
    logic [31:0] rd;
    logic err;
    logic signed [15:0] prev;
    logic signed [15:0] pv_tab [7] = '{16'sh0001, 16'sh0032, 16'sh0064, 16'sh00fa,
        -16'sh0014, 16'sh044c, 16'sh03e8};
    logic signed [15:0] sq_tab [7] = '{16'sh0000, 16'sh0000, 16'sh013c, 16'sh01f4,
        -16'sh0014, 16'sh044c, 16'sh03e8};
    logic signed [15:0] sl_tab [4] = '{16'sh0069, 16'sh006e, 16'sh0073, 16'sh0076};

    mvoc_top #(.P_TICK_CYC(TICK)) i_mvoc_top (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_apb(i_apb), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_calc_mv(i_calc_mv),
        .i_pv_in(i_pv_in), .i_pv_err(i_pv_err), .o_mv(o_mv), .o_heat(o_heat),
        .o_cool(o_cool), .o_pv(o_pv)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        if (fails == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
        chk32({16'h0000, got}, {16'h0000, exp}, what);
    endtask

    task automatic chk_out(input logic [15:0] mv, input logic [15:0] ht, input logic [15:0] cl);
        chk16(o_mv, mv, "mv");
        chk16(o_heat, ht, "heat");
        chk16(o_cool, cl, "cool");
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic do_wr, input logic [7:0] addr, input logic [31:0] wdata);
        @(posedge i_mclk);
        i_apb.paddr <= addr;
        i_apb.pwrite <= do_wr;
        i_apb.pwdata <= wdata;
        i_apb.psel <= 1'b1;
        @(posedge i_mclk);
        i_apb.penable <= 1'b1;
        @(posedge i_mclk);
        for (n = 0; o_pready !== 1'b1; n++)
        begin
            if (n == 50)
            begin
                fails++;
                conclude();
            end
            @(posedge i_mclk);
        end
        rd = o_prdata;
        err = o_pslverr;
        i_apb.psel <= 1'b0;
        i_apb.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] wdata);
        apb(1'b1, addr, wdata);
        repeat (3) @(posedge i_mclk);
    endtask

    task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0000_0000);
        chk32(rd, exp, "read data");
    endtask

    task automatic drive(input logic signed [15:0] calc, input logic signed [15:0] pv,
        input logic e);
        @(posedge i_mclk);
        i_calc_mv <= calc;
        i_pv_in <= pv;
        i_pv_err <= e;
        repeat (3) @(posedge i_mclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end

    initial
    begin
        i_rst_n = 1'b0;
        i_apb = '0;
        i_calc_mv = 16'sh0000;
        i_pv_in = 16'sh0000;
        i_pv_err = 1'b0;
        fails = 0;
        checked = 0;
        repeat (20) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        // Reset values
        rdchk(REG_MV_HI, 32'h0000_03e8);
        rdchk(REG_MV_LO, 32'h0000_0000);
        rdchk(REG_CTRL, 32'h0000_0000);
        rdchk(REG_STOP_MV, 32'h0000_0000);
        rdchk(REG_ERR_MV, 32'h0000_0000);
        rdchk(REG_LOWCUT, 32'h0000_0000);
        rdchk(REG_RATE, 32'h0000_0000);
        apb(1'b1, 8'h40, 32'h0000_1234);
        chk32({31'h0, err}, 32'h1, "unmapped write");
        rdchk(8'h40, 32'h0000_0000);
        chk32({31'h0, err}, 32'h1, "unmapped read");
        // Low-cut saturates at full scale
        wr(REG_LOWCUT, 32'h0000_05dc);
        rdchk(REG_LOWCUT, 32'h0000_03e8);
        wr(REG_LOWCUT, 32'h0000_0064);
        // Clamp of the calculated value, no slew at rate zero
        wr(REG_MV_HI, 32'h0000_0320);
        wr(REG_MV_LO, 32'h0000_0064);
        drive(16'sh0384, 16'sh0000, 1'b0);
        chk_out(16'sh0320, 16'sh0320, 16'sh0000);
        drive(16'sh0032, 16'sh0000, 1'b0);
        chk_out(16'sh0064, 16'sh0064, 16'sh0000);
        // Manual value and its optional limit
        wr(REG_MAN_MV, 32'h0000_03fc);
        wr(REG_CTRL, 32'h0000_0008);
        chk_out(16'sh03fc, 16'sh03fc, 16'sh0000);
        wr(REG_CTRL, 32'h0000_000a);
        chk_out(16'sh0320, 16'sh0320, 16'sh0000);
        wr(REG_MAN_MV, 32'h0000_0014);
        chk_out(16'sh0064, 16'sh0064, 16'sh0000);
        // Priority with every source requested at once
        wr(REG_STOP_MV, 32'h0000_0406);
        wr(REG_CTRL, 32'h0000_0018);
        drive(16'sh01f4, 16'sh0000, 1'b1);
        chk_out(16'sh0014, 16'sh0014, 16'sh0000);
        wr(REG_CTRL, 32'h0000_0010);
        chk_out(16'sh0406, 16'sh0406, 16'sh0000);
        rdchk(REG_STATUS, 32'h0000_0007);
        wr(REG_STOP_MV, -32'sh0000_012c);
        chk_out(-16'sh0032, 16'sh0000, 16'sh0000);
        wr(REG_CTRL, 32'h0000_0000);
        chk_out(16'sh0000, 16'sh0000, 16'sh0000);
        wr(REG_ERR_MV, -32'sh0000_001e);
        chk_out(-16'sh001e, 16'sh0000, 16'sh0000);
        // Heat/cool steering of stop and error values
        wr(REG_CTRL, 32'h0000_0014);
        chk_out(-16'sh012c, 16'sh0000, 16'sh012c);
        wr(REG_STOP_MV, 32'h0000_0190);
        chk_out(16'sh0190, 16'sh0190, 16'sh0000);
        wr(REG_CTRL, 32'h0000_0004);
        wr(REG_ERR_MV, -32'sh0000_02bc);
        chk_out(-16'sh02bc, 16'sh0000, 16'sh02bc);
        wr(REG_ERR_MV, 32'h0000_00fa);
        chk_out(16'sh00fa, 16'sh00fa, 16'sh0000);
        // One limit pair on the signed heat/cool output
        wr(REG_MV_LO, -32'sh0000_01f4);
        wr(REG_MV_HI, 32'h0000_01f4);
        rdchk(REG_MV_LO, 32'h0000_fe0c);
        drive(-16'sh02bc, 16'sh00fa, 1'b0);
        chk_out(-16'sh01f4, 16'sh0000, 16'sh01f4);
        drive(16'sh0384, 16'sh00fa, 1'b0);
        chk_out(16'sh01f4, 16'sh01f4, 16'sh0000);
        // Square root stage
        chk16(o_pv, 16'sh00fa, "pv disabled");
        wr(REG_CTRL, 32'h0000_0001);
        rdchk(REG_CTRL, 32'h0000_0001);
        for (int k = 0; k < 7; k++)
        begin
            drive(16'sh0000, pv_tab[k], 1'b0);
            chk16(o_pv, sq_tab[k], "pv extracted");
        end
        rdchk(REG_PV_OUT, 32'h0000_03e8);
        // Slew of 5.0 %/s: 0.5 % per control period, no overshoot
        wr(REG_CTRL, 32'h0000_0000);
        wr(REG_MV_LO, 32'h0000_0000);
        wr(REG_MV_HI, 32'h0000_03e8);
        drive(16'sh0064, 16'sh0000, 1'b0);
        wr(REG_RATE, 32'h0000_0032);
        @(posedge i_mclk);
        i_calc_mv <= 16'sh0076;
        for (int k = 0; k < 4; k++)
        begin
            prev = o_mv;
            n = 0;
            while (o_mv === prev)
            begin
                if (n == 40)
                begin
                    fails++;
                    conclude();
                end
                @(posedge i_mclk);
                n++;
            end
            if (k > 0)
                chk16(16'(n), 16'(TICK), "slew period");
            chk16(o_mv, sl_tab[k], "slew step");
        end
        repeat (40) @(posedge i_mclk);
        chk16(o_mv, 16'sh0076, "slew settled");
        rdchk(REG_MV_OUT, 32'h0000_0076);
        rdchk(REG_STATUS, 32'h0000_0000);
        // Slew bypassed while tuning and under on/off control
        wr(REG_CTRL, 32'h0000_0020);
        drive(16'sh012c, 16'sh0000, 1'b0);
        chk16(o_mv, 16'sh012c, "tuning");
        rdchk(REG_STATUS, 32'h0000_0004);
        wr(REG_CTRL, 32'h0000_0040);
        drive(16'sh0064, 16'sh0000, 1'b0);
        chk16(o_mv, 16'sh0064, "on/off");
        conclude();
    end
endmodule
